/* File: rtl/draw_pkg.sv */
/*
   Shared constants and types for the draw-and-advance execution datapath.
   Assumes a single processor clock and a synchronous active-high reset.
*/
// Overview of operation
// - Draw-and-advance writes one foreground colour pixel at destination Y/X address.
// - Right after the write, destination register gets increment register added.
// - Source and destination must come from one register file; mixing is refused.
// - Packed address: Y in upper 16 bits, X in lower 16 bits.
// - Y halves and X halves are added separately, no carry between them.
// - Origin upper left; larger Y lies lower; negative Y increment moves up.
// - Pixel placement is measured from the upper left screen origin.
// - Decrement-branch decrements counter, branches only when result is nonzero.
// - Y/X destination becomes a linear address through the pitch conversion value.
// - Pixel width for writes comes from the pixel width setting.
// - Selected pixel operation combines source and destination pixels before storing.
package draw_pkg;

   localparam int DATA_W     = 32;
   localparam int HALF_W     = 16;
   localparam int WORD_W     = 16;
   localparam int WORD_SHIFT = 4;
   localparam int REG_IDX_W  = 4;
   localparam int REG_COUNT  = 16;
   localparam int FILE_COUNT = 2;

   // Position of the Y half inside a packed address
   localparam int Y_LSB = 16;
   localparam int X_LSB = 0;

   localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

   // Instruction codes accepted on the command port
   typedef enum logic [1:0]
   {
      CMD_NONE            = 2'b00,
      CMD_MOVE_IMMEDIATE  = 2'b01,
      CMD_DRAW_ADVANCE    = 2'b10,
      CMD_DECREMENT_BRANCH = 2'b11
   } cmd_t;

   // Pixel processing operations
   typedef enum logic [2:0]
   {
      PIX_REPLACE = 3'b000,
      PIX_AND     = 3'b001,
      PIX_OR      = 3'b010,
      PIX_XOR     = 3'b011,
      PIX_ADD     = 3'b100,
      PIX_SUB     = 3'b101
   } pix_op_t;

   // Execution sequencer states
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_READ  = 3'b001,
      ST_WAIT  = 3'b010,
      ST_WRITE = 3'b011,
      ST_DONE  = 3'b100
   } state_t;

endpackage

/* File: rtl/pixel_if.sv */
/*
   Carrier between the sequencer and the pixel combiner.
   Assumes both ends sit in the same clock domain; purely combinational path.
*/
`timescale 1ns/10ps
`default_nettype none

interface pixel_if;
   logic [draw_pkg::WORD_W-1:0] color_word;
   logic [draw_pkg::WORD_W-1:0] dst_word;
   logic [3:0]                  bit_off;
   logic [2:0]                  width_log2;
   draw_pkg::pix_op_t           op;
   logic                        transp;
   logic [draw_pkg::WORD_W-1:0] result_word;
   logic [draw_pkg::WORD_W-1:0] result_mask;

   modport combiner (input color_word, dst_word, bit_off, width_log2, op, transp,
                     output result_word, result_mask);
   modport sequencer (output color_word, dst_word, bit_off, width_log2, op, transp,
                      input result_word, result_mask);
endinterface

`default_nettype wire

/* File: rtl/pixel_combiner.sv */
/*
   Combines the foreground colour with the destination memory word for one pixel.
   Assumes bit_off is a multiple of the pixel width; the column term keeps it so, but screen_offset and the row term must too.
*/
`timescale 1ns/10ps
`default_nettype none

module pixel_combiner
(
   pixel_if.combiner px
);

   // Mask of one pixel of width 2**w at the low end of a word
   function automatic logic [draw_pkg::WORD_W-1:0] field_mask(input logic [2:0] w);
      logic [draw_pkg::WORD_W-1:0] m;
      m = 16'h0000;
      case (w)
         3'h0:    m = 16'h0001;
         3'h1:    m = 16'h0003;
         3'h2:    m = 16'h000F;
         3'h3:    m = 16'h00FF;
         default: m = 16'hFFFF;
      endcase
      return m;
   endfunction

   logic [draw_pkg::WORD_W-1:0] mask;
   logic [draw_pkg::WORD_W-1:0] src_al;
   logic [draw_pkg::WORD_W-1:0] dst_al;
   logic [draw_pkg::WORD_W-1:0] res;
   logic                        clear_px;

   // Colour taken from the same bit lanes the pixel occupies
   assign mask   = field_mask(px.width_log2) << px.bit_off;
   assign src_al = px.color_word & mask;
   assign dst_al = px.dst_word & mask;

   // Arithmetic stays inside the field; carries out of it are dropped by the mask
   always_comb
   begin
      case (px.op)
         draw_pkg::PIX_AND: res = src_al & dst_al;
         draw_pkg::PIX_OR:  res = src_al | dst_al;
         draw_pkg::PIX_XOR: res = src_al ^ dst_al;
         draw_pkg::PIX_ADD: res = (src_al + dst_al) & mask;
         draw_pkg::PIX_SUB: res = (dst_al - src_al) & mask;
         default:           res = src_al;
      endcase
   end

   // Transparency leaves the pixel untouched when the result is zero
   assign clear_px       = px.transp && ((res & mask) == draw_pkg::WORD_ZERO);
   assign px.result_mask = clear_px ? draw_pkg::WORD_ZERO : mask;
   assign px.result_word = (px.dst_word & ~mask) | (res & mask);

endmodule

`default_nettype wire

/* File: rtl/draw_advance_unit.sv */
/*
   Execution datapath for move-immediate, draw-and-advance and decrement-branch.
   Holds both register files, forms the pixel address, does read-modify-write
   of the pixel memory word and advances the destination register.
   Assumes the pixel memory answers a read with mem_rvalid some cycles later
   and takes a write in the cycle mem_we is high.
*/
`timescale 1ns/10ps
`default_nettype none

module draw_advance_unit
#(
   parameter int PITCH_SHIFT_W = 5
)
(
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // Command port
   input  wire logic                          cmd_valid,
   input  wire draw_pkg::cmd_t                cmd_code,
   input  wire logic                          cmd_src_file,
   input  wire logic [draw_pkg::REG_IDX_W-1:0] cmd_src_idx,
   input  wire logic                          cmd_dst_file,
   input  wire logic [draw_pkg::REG_IDX_W-1:0] cmd_dst_idx,
   input  wire logic [draw_pkg::DATA_W-1:0]   cmd_imm,
   output logic                               cmd_ready,
   output logic                               cmd_done,
   output logic                               cmd_illegal,
   output logic                               branch_taken,
   output logic [draw_pkg::DATA_W-1:0]        branch_target,
   // Drawing setup
   input  wire logic [draw_pkg::DATA_W-1:0]   foreground_color_reg,
   input  wire logic [PITCH_SHIFT_W-1:0]      dest_pitch_conversion_reg,
   input  wire logic [draw_pkg::HALF_W-1:0]   pixel_width_reg,
   input  wire logic [draw_pkg::DATA_W-1:0]   screen_offset,
   input  wire draw_pkg::pix_op_t             pixel_op,
   input  wire logic                          transparency_en,
   // Register read-back
   input  wire logic                          peek_file,
   input  wire logic [draw_pkg::REG_IDX_W-1:0] peek_idx,
   output logic [draw_pkg::DATA_W-1:0]        peek_data,
   // Pixel memory
   output logic                               mem_re,
   output logic                               mem_we,
   output logic [draw_pkg::DATA_W-draw_pkg::WORD_SHIFT-1:0] mem_addr,
   output logic [draw_pkg::WORD_W-1:0]        mem_wdata,
   output logic [draw_pkg::WORD_W-1:0]        mem_wmask,
   input  wire logic                          mem_rvalid,
   input  wire logic [draw_pkg::WORD_W-1:0]   mem_rdata
);

   // Elaboration guard: the row shift port must be 1 to 5 bits wide
   if (PITCH_SHIFT_W < 1 || PITCH_SHIFT_W > 5)
   begin
      $error("PITCH_SHIFT_W must lie in 1..5");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Pixel width setting to log2; unsupported widths fall back to one bit
   function automatic logic [2:0] width_log2(input logic [draw_pkg::HALF_W-1:0] w);
      case (w)
         16'h0002: return 3'h1;
         16'h0004: return 3'h2;
         16'h0008: return 3'h3;
         16'h0010: return 3'h4;
         default:  return 3'h0;
      endcase
   endfunction

   // Flat register index from file and number
   function automatic logic [draw_pkg::REG_IDX_W:0] reg_sel(input logic f,
                                                           input logic [3:0] i);
      return {f, i};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Storage and state

   logic [draw_pkg::DATA_W-1:0] regs [draw_pkg::FILE_COUNT*draw_pkg::REG_COUNT];
   draw_pkg::state_t            state_q;
   draw_pkg::state_t            state_d;
   logic [draw_pkg::REG_IDX_W:0] src_q;
   logic [draw_pkg::REG_IDX_W:0] dst_q;
   logic [draw_pkg::DATA_W-1:0] bitaddr_q;

   pixel_if px ();

   ////////////////////////////////////////////////////////////////////////////
   // Command decode

   logic                         take;
   logic                         mixed_files;
   logic [draw_pkg::REG_IDX_W:0] src_sel;
   logic [draw_pkg::REG_IDX_W:0] dst_sel;
   logic [draw_pkg::DATA_W-1:0]  dst_val;
   logic [draw_pkg::DATA_W-1:0]  src_val;
   logic [draw_pkg::DATA_W-1:0]  count_dec;
   logic                         count_nz;
   logic                         draw_go;

   // Only a command offered while ready is announced counts as taken
   assign take        = cmd_valid && cmd_ready && (state_q == draw_pkg::ST_IDLE);
   assign mixed_files = cmd_src_file != cmd_dst_file;
   assign src_sel     = reg_sel(cmd_src_file, cmd_src_idx);
   assign dst_sel     = reg_sel(cmd_dst_file, cmd_dst_idx);
   assign dst_val     = regs[dst_sel];
   assign src_val     = regs[src_sel];
   assign count_dec   = dst_val - 32'h0000_0001;
   assign count_nz    = count_dec != 32'h0000_0000;
   assign draw_go     = take && cmd_code == draw_pkg::CMD_DRAW_ADVANCE && !mixed_files;

   ////////////////////////////////////////////////////////////////////////////
   // Y/X to linear bit address

   logic [draw_pkg::HALF_W-1:0] pos_y;
   logic [draw_pkg::HALF_W-1:0] pos_x;
   logic [2:0]                  wlog;
   logic [draw_pkg::DATA_W-1:0] row_bits;
   logic [draw_pkg::DATA_W-1:0] col_bits;
   logic [draw_pkg::DATA_W-1:0] lin_addr;

   assign pos_y    = dst_val[draw_pkg::Y_LSB +: draw_pkg::HALF_W];
   assign pos_x    = dst_val[draw_pkg::X_LSB +: draw_pkg::HALF_W];
   assign wlog     = width_log2(pixel_width_reg);
   // Rows run downward from the top-left origin, columns to the right
   assign row_bits = {16'h0000, pos_y} << dest_pitch_conversion_reg;
   assign col_bits = {16'h0000, pos_x} << wlog;
   assign lin_addr = screen_offset + row_bits + col_bits;

   ////////////////////////////////////////////////////////////////////////////
   // Advance: halves added separately, no carry from X into Y

   logic [draw_pkg::HALF_W-1:0] adv_y;
   logic [draw_pkg::HALF_W-1:0] adv_x;
   logic [draw_pkg::DATA_W-1:0] adv_val;

   assign adv_y   = regs[dst_q][draw_pkg::Y_LSB +: draw_pkg::HALF_W]
                  + regs[src_q][draw_pkg::Y_LSB +: draw_pkg::HALF_W];
   assign adv_x   = regs[dst_q][draw_pkg::X_LSB +: draw_pkg::HALF_W]
                  + regs[src_q][draw_pkg::X_LSB +: draw_pkg::HALF_W];
   assign adv_val = {adv_y, adv_x};

   ////////////////////////////////////////////////////////////////////////////
   // Pixel combine

   assign px.color_word = foreground_color_reg[draw_pkg::WORD_W-1:0];
   // Read word is combined in its answer cycle; a held copy would be one draw stale
   assign px.dst_word   = mem_rdata;
   assign px.bit_off    = bitaddr_q[draw_pkg::WORD_SHIFT-1:0];
   assign px.width_log2 = wlog;
   assign px.op         = pixel_op;
   assign px.transp     = transparency_en;

   pixel_combiner u_combiner
   (
      .px (px)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer next state

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         draw_pkg::ST_IDLE:
            if (take && cmd_code == draw_pkg::CMD_DRAW_ADVANCE && !mixed_files)
               state_d = draw_pkg::ST_READ;
         draw_pkg::ST_READ:  state_d = draw_pkg::ST_WAIT;
         draw_pkg::ST_WAIT:
            if (mem_rvalid)
               state_d = draw_pkg::ST_WRITE;
         draw_pkg::ST_WRITE: state_d = draw_pkg::ST_DONE;
         draw_pkg::ST_DONE:  state_d = draw_pkg::ST_IDLE;
         default:            state_d = draw_pkg::ST_IDLE;
      endcase
   end

   // State and operand capture
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q   <= draw_pkg::ST_IDLE;
         src_q     <= '0;
         dst_q     <= '0;
         bitaddr_q <= draw_pkg::REG_RESET;
      end
      else
      begin
         state_q <= state_d;
         if (take)
         begin
            src_q     <= src_sel;
            dst_q     <= dst_sel;
            bitaddr_q <= lin_addr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register files; only the written entry changes

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < draw_pkg::FILE_COUNT*draw_pkg::REG_COUNT; i++)
            regs[i] <= draw_pkg::REG_RESET;
      end
      else if (take && cmd_code == draw_pkg::CMD_MOVE_IMMEDIATE)
         regs[dst_sel] <= cmd_imm;
      else if (take && cmd_code == draw_pkg::CMD_DECREMENT_BRANCH)
         regs[dst_sel] <= count_dec;
      else if (state_q == draw_pkg::ST_WRITE)
         regs[dst_q] <= adv_val;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory port; the write lands in the same cycle the advance is stored

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mem_re    <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= '0;
         mem_wdata <= draw_pkg::WORD_ZERO;
         mem_wmask <= draw_pkg::WORD_ZERO;
      end
      else
      begin
         mem_re <= (state_d == draw_pkg::ST_READ);
         mem_we <= (state_q == draw_pkg::ST_WAIT) && mem_rvalid;
         if (take)
            mem_addr <= lin_addr[draw_pkg::DATA_W-1:draw_pkg::WORD_SHIFT];
         if (state_q == draw_pkg::ST_WAIT && mem_rvalid)
         begin
            mem_wdata <= (mem_rdata & ~px.result_mask) | (px.result_word & px.result_mask);
            mem_wmask <= px.result_mask;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command status; draw completes at ST_DONE, others in one cycle

   logic quick_done;

   assign quick_done = take && (cmd_code != draw_pkg::CMD_DRAW_ADVANCE || mixed_files);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cmd_ready     <= 1'b0;
         cmd_done      <= 1'b0;
         cmd_illegal   <= 1'b0;
         branch_taken  <= 1'b0;
         branch_target <= draw_pkg::REG_RESET;
         peek_data     <= draw_pkg::REG_RESET;
      end
      else
      begin
         cmd_ready    <= (state_d == draw_pkg::ST_IDLE) && !draw_go;
         cmd_done     <= quick_done || (state_q == draw_pkg::ST_DONE);
         cmd_illegal  <= take && cmd_code == draw_pkg::CMD_DRAW_ADVANCE && mixed_files;
         branch_taken <= take && cmd_code == draw_pkg::CMD_DECREMENT_BRANCH && count_nz;
         if (take)
            branch_target <= cmd_imm;
         peek_data    <= regs[reg_sel(peek_file, peek_idx)];
      end
   end

endmodule

`default_nettype wire

/* File: sim/draw_chk.sv */
/*
   Port checker for the draw-and-advance unit.
   Assumes it is bound onto the unit top; one clock, synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none

module draw_chk
(
   // Clock and reset
   input wire logic                        clk,
   input wire logic                        rst,
   // Command port
   input wire logic                        cmd_valid,
   input wire draw_pkg::cmd_t              cmd_code,
   input wire logic                        cmd_src_file,
   input wire logic                        cmd_dst_file,
   input wire logic [draw_pkg::DATA_W-1:0] cmd_imm,
   input wire logic                        cmd_ready,
   input wire logic                        cmd_done,
   input wire logic                        cmd_illegal,
   input wire logic                        branch_taken,
   input wire logic [draw_pkg::DATA_W-1:0] branch_target,
   // Pixel memory
   input wire logic                        mem_re,
   input wire logic                        mem_we
);
   // Commands taken at this edge, by kind
   wire take = cmd_valid && cmd_ready;
   wire draw = take && cmd_code == draw_pkg::CMD_DRAW_ADVANCE;
   wire brch = take && cmd_code == draw_pkg::CMD_DECREMENT_BRANCH;
   wire mixd = cmd_src_file != cmd_dst_file;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   a_draw_reads: assert property (draw && !mixd |=> mem_re && !cmd_done)
      else $error("draw did not start a read");
   a_draw_busy: assert property (draw && !mixd |=> !cmd_ready [*3])
      else $error("unit ready while drawing");
   a_mixed_refused: assert property (draw && mixd |=> cmd_illegal && cmd_done && !mem_re)
      else $error("mixed files not refused");
   a_illegal_quiet: assert property (cmd_illegal |-> cmd_done && !mem_we)
      else $error("refused draw wrote memory");
   a_write_then_done: assert property (mem_we |=> !mem_we ##1 (cmd_done && cmd_ready))
      else $error("write not followed by completion");
   a_branch_done: assert property (brch |=> cmd_done && !cmd_illegal && !mem_re)
      else $error("branch did not finish next cycle");
   a_branch_target: assert property (brch |=> branch_target == $past(cmd_imm))
      else $error("branch target not captured");
   a_taken_with_done: assert property (branch_taken |-> cmd_done)
      else $error("branch taken without completion");
   a_done_pulse: assert property (cmd_done && !cmd_valid |=> !cmd_done)
      else $error("completion held too long");
endmodule

`default_nettype wire

/* File: sim/tb_draw_and_advance_pixel.sv */
/*
   Self-checking bench for the draw-and-advance unit.
   Stands in for the pixel memory itself; one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_draw_and_advance_pixel;
   typedef struct {logic [31:0] dst, inc; int lg; draw_pkg::pix_op_t op;
                   logic [15:0] rd; int lt; logic t; logic f;} row_t;
   logic              clk, rst, cmd_valid, cmd_src_file, cmd_dst_file, tr, peek_file;
   logic              cmd_ready, cmd_done, cmd_illegal, branch_taken, mem_re, mem_we;
   logic              mem_rvalid, ill_seen, tk_seen;
   draw_pkg::cmd_t    cmd_code;
   draw_pkg::pix_op_t pop;
   logic [3:0]        cmd_src_idx, cmd_dst_idx, peek_idx;
   logic [31:0]       cmd_imm, fg, s_off, peek_data, branch_target;
   logic [4:0]        pitch;
   logic [15:0]       pw, mem_wdata, mem_wmask, mem_rdata, rd_word, w_data, w_mask;
   logic [27:0]       mem_addr, w_addr;
   int                num_errors, total_checks, lat, n_re, n_we;
   // Ordinary draws: plain step, wraps of each half, negative Y, every op
   row_t rows [7] = '{
      '{32'h001E0040, 32'h00010000, 2, draw_pkg::PIX_REPLACE, 16'h0000, 1, 0, 0},
      '{32'h001E0040, 32'h00010002, 0, draw_pkg::PIX_AND, 16'hFFFF, 3, 0, 1},
      '{32'h0005FFFF, 32'h00000006, 3, draw_pkg::PIX_OR, 16'h1234, 2, 0, 0},
      '{32'hFFFF0003, 32'hFFFF0001, 4, draw_pkg::PIX_XOR, 16'h0F0F, 1, 0, 1},
      '{32'h00020005, 32'h00000001, 1, draw_pkg::PIX_ADD, 16'hFFFF, 1, 0, 0},
      '{32'h00030007, 32'h00010000, 2, draw_pkg::PIX_SUB, 16'h0000, 2, 0, 0},
      '{32'h00000000, 32'h00000000, 4, draw_pkg::PIX_XOR, 16'h5A3C, 1, 1, 0}};

   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   draw_advance_unit uut
   (
      .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_src_file(cmd_src_file), .cmd_src_idx(cmd_src_idx), .cmd_dst_file(cmd_dst_file),
      .cmd_dst_idx(cmd_dst_idx), .cmd_imm(cmd_imm), .cmd_ready(cmd_ready),
      .cmd_done(cmd_done), .cmd_illegal(cmd_illegal), .branch_taken(branch_taken),
      .branch_target(branch_target), .foreground_color_reg(fg),
      .dest_pitch_conversion_reg(pitch), .pixel_width_reg(pw), .screen_offset(s_off),
      .pixel_op(pop), .transparency_en(tr), .peek_file(peek_file), .peek_idx(peek_idx),
      .peek_data(peek_data), .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_wmask(mem_wmask), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Memory stand-in: read data is junk except in the answer cycle
   always
   begin
      @(posedge clk);
      #1;
      mem_rvalid = 0;
      mem_rdata = ~rd_word;
      if (mem_re === 1'b1)
      begin
         n_re++;
         repeat (lat) @(posedge clk);
         #1;
         mem_rvalid = 1;
         mem_rdata = rd_word;
      end
   end

   // Write capture; the write pulse stands one cycle
   always @(posedge clk)
      if (mem_we === 1'b1)
      begin
         w_addr = mem_addr;
         w_data = mem_wdata;
         w_mask = mem_wmask;
         n_we++;
      end

   task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One command, held until taken, then waits for completion
   task automatic issue(input draw_pkg::cmd_t c, input logic sf, input logic [3:0] si,
                        input logic df, input logic [3:0] di, input logic [31:0] imm);
      int k;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 50)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      cmd_valid = 1;
      cmd_code = c;
      cmd_src_file = sf;
      cmd_src_idx = si;
      cmd_dst_file = df;
      cmd_dst_idx = di;
      cmd_imm = imm;
      @(posedge clk);
      #1;
      cmd_valid = 0;
      k = 0;
      while (cmd_done !== 1'b1 && k < 20)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      ill_seen = cmd_illegal;
      tk_seen = branch_taken;
      check32("cmd_done", 32'h1, {31'h0, cmd_done});
      // One idle edge so the next call never re-raises valid in this time step
      @(posedge clk);
      #1;
   endtask

   task automatic peek(input logic f, input logic [3:0] i, output logic [31:0] v);
      peek_file = f;
      peek_idx = i;
      @(posedge clk);
      #1;
      v = peek_data;
   endtask

   function automatic logic [15:0] comb(input draw_pkg::pix_op_t o, input logic [15:0] s, d);
      case (o)
         draw_pkg::PIX_AND: return s & d;
         draw_pkg::PIX_OR:  return s | d;
         draw_pkg::PIX_XOR: return s ^ d;
         draw_pkg::PIX_ADD: return d + s;
         draw_pkg::PIX_SUB: return d - s;
         default:           return s;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] ba, v;
      logic [15:0] m, em, res;
      int          w, off, nw, nr;
      {cmd_valid, cmd_src_file, cmd_dst_file, tr, peek_file} = '0;
      {cmd_src_idx, cmd_dst_idx, peek_idx, cmd_imm, rd_word} = '0;
      {num_errors, total_checks, n_re, n_we} = '0;
      cmd_code = draw_pkg::CMD_NONE;
      pop = draw_pkg::PIX_REPLACE;
      fg = 32'h1234_5A3C;
      s_off = 32'h0000_1000;
      pitch = 5'h0A;
      pw = 16'h0001;
      lat = 1;
      rst = 1;
      repeat (8) @(posedge clk);
      #1;
      rst = 0;
      check32("ready_1st", 32'h0, {31'h0, cmd_ready});
      @(posedge clk);
      #1;
      check32("ready_2nd", 32'h1, {31'h0, cmd_ready});
      peek(1, 4'h5, v);
      check32("reset_reg", 32'h0, v);
      foreach (rows[i])
      begin
         w = 1 << rows[i].lg;
         pw = 16'(w);
         pop = rows[i].op;
         tr = rows[i].t;
         rd_word = rows[i].rd;
         lat = rows[i].lt;
         nw = n_we;
         issue(draw_pkg::CMD_MOVE_IMMEDIATE, 0, 0, rows[i].f, 4'h2, rows[i].dst);
         issue(draw_pkg::CMD_MOVE_IMMEDIATE, 0, 0, rows[i].f, 4'h1, rows[i].inc);
         issue(draw_pkg::CMD_DRAW_ADVANCE, rows[i].f, 4'h1, rows[i].f, 4'h2, 0);
         ba = s_off + ({16'h0, rows[i].dst[31:16]} << pitch)
              + ({16'h0, rows[i].dst[15:0]} << rows[i].lg);
         off = ba[3:0];
         m = 16'(((32'h1 << w) - 1) << off);
         res = comb(pop, fg[15:0] >> off, rows[i].rd >> off) & 16'((32'h1 << w) - 1);
         em = (rows[i].t && res == 16'h0) ? 16'h0 : m;
         check32("writes", 32'(nw + 1), 32'(n_we));
         check32("addr", {4'h0, ba[31:4]}, {4'h0, w_addr});
         check32("wmask", {16'h0, em}, {16'h0, w_mask});
         check32("wdata", {16'h0, 16'(res << off) & em}, {16'h0, w_data & em});
         peek(rows[i].f, 4'h2, v);
         check32("advance", {rows[i].dst[31:16] + rows[i].inc[31:16],
                 rows[i].dst[15:0] + rows[i].inc[15:0]}, v);
      end
      // Decrement-branch: taken on 2 -> 1, falls through on 1 -> 0
      issue(draw_pkg::CMD_MOVE_IMMEDIATE, 0, 0, 0, 4'h0, 32'h2);
      issue(draw_pkg::CMD_DECREMENT_BRANCH, 0, 0, 0, 4'h0, 32'h0000_2180);
      check32("taken", 32'h1, {31'h0, tk_seen});
      check32("target", 32'h0000_2180, branch_target);
      issue(draw_pkg::CMD_DECREMENT_BRANCH, 0, 0, 0, 4'h0, 32'h0000_2180);
      check32("fall_through", 32'h0, {31'h0, tk_seen});
      peek(0, 4'h0, v);
      check32("count", 32'h0, v);
      // Mixed register files: refused, no memory access, no advance
      nr = n_re;
      issue(draw_pkg::CMD_DRAW_ADVANCE, 1, 4'h1, 0, 4'h2, 0);
      check32("illegal", 32'h1, {31'h0, ill_seen});
      check32("reads", 32'(nr), 32'(n_re));
      peek(0, 4'h2, v);
      check32("no_advance", 32'h0000_0000, v);
      report_and_stop();
   end

   // Watchdog well beyond the hundred or so cycles the run needs
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
endmodule

bind draw_advance_unit draw_chk chk
(
   .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
   .cmd_src_file(cmd_src_file), .cmd_dst_file(cmd_dst_file), .cmd_imm(cmd_imm),
   .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_illegal(cmd_illegal),
   .branch_taken(branch_taken), .branch_target(branch_target),
   .mem_re(mem_re), .mem_we(mem_we)
);

`default_nettype wire
